// file: rtl/ddc_pkg.sv
// Package with constants and types of the dual converter command unit.
package ddc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_HI = 21;
    localparam int CMD_LO = 19;
    localparam int CHN_HI = 18;
    localparam int CHN_LO = 16;
    localparam int PD_MODE_HI = 5;
    localparam int PD_MODE_LO = 4;
    localparam int SEL_B_BIT = 1;
    localparam int SEL_A_BIT = 0;
    localparam int SYNC_HIGH_NS = 15;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYNC_HIGH_CYC =
        (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h17;

    typedef enum logic [2:0] {
        CMD_WRITE_IN = 3'h0,
        CMD_UPDATE = 3'h1,
        CMD_WRITE_ALL = 3'h2,
        CMD_WRITE_UPD = 3'h3,
        CMD_POWER = 3'h4,
        CMD_RESET = 3'h5,
        CMD_LOAD_CTL = 3'h6,
        CMD_RSVD = 3'h7
    } ddc_cmd_t;

    localparam logic [2:0] CHN_A = 3'h0;
    localparam logic [2:0] CHN_B = 3'h1;
    localparam logic [2:0] CHN_ALL = 3'h7;

    typedef enum logic [1:0] {
        PD_NORMAL = 2'h0,
        PD_1K = 2'h1,
        PD_100K = 2'h2,
        PD_TRI = 2'h3
    } ddc_pd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_DONE = 2'h3
    } ddc_st_t;

    typedef struct packed {
        logic [15:0] code_a;
        logic [15:0] code_b;
    } ddc_pair_t;

    typedef struct packed {
        ddc_pd_t mode_a;
        ddc_pd_t mode_b;
    } ddc_pwr_t;
endpackage

// file: rtl/ddc_cmd_unit.sv
// Serial command receiver and register control for a dual converter.
`timescale 1ns/10ps
// Functional notes
// - A falling frame select starts a frame; data shifts on serial clock falls.
// - The 24th falling edge takes the last bit and runs the command.
// - Frame is two ignored bits, command, channel, then 16 data bits.
// - Commands: write input, update, write and update all, write and update.
// - Channel 000 is A, 001 is B, 111 is both; others reserved.
// - Data word is straight binary held in the converter register.
// - Frame select rising early discards the frame with no change.
// - After power-up outputs hold zero or midscale until a valid frame.
// - Load strobe is ignored during power-on reset; the clear pin is synchronised but never used.
// - Command 101 clears data registers; with DB0 set also control registers.
// - Command 100 sets power mode from DB5 and DB4.
// - DB1 picks channel B, DB0 channel A for the power mode.
// - Leaving power-down shows input register if strobe low, else held value.
// - Converter register changes only by command 101 while its channel is powered down.
// - Low load strobe copies input registers into converter registers.
// - Strobe updates a converter register only if its input was written.
// - Command 110 sets per-channel auto update bits; default zero.
module ddc_cmd_unit #(
    parameter logic MIDSCALE_VARIANT = 1'b0
) (
    // Clock and reset.
    input  wire logic             SYS_CLK,
    input  wire logic             RESET,
    // Serial host pins.
    input  wire logic             FRAME_SELECT_N,
    input  wire logic             SERIAL_CLK,
    input  wire logic             SERIAL_DATA_IN,
    // Hardware control pins.
    input  wire logic             LOAD_STROBE_N,
    input  wire logic             CLEAR_INPUT_N,
    // Converter state and frame-done pulse.
    output ddc_pkg::ddc_pair_t    CONV_CODE,
    output ddc_pkg::ddc_pwr_t     POWER_MODE,
    output logic [1:0]            AUTO_LOAD,
    output logic                  FRAME_DONE
);
    typedef struct packed {
        logic [2:0]       fs_s;
        logic [2:0]       sck_s;
        logic [1:0]       sdi_s;
        logic [1:0]       ld_s;
        logic [1:0]       clr_s;
        logic             por;
        ddc_pkg::ddc_st_t st;
        logic [4:0]       cnt;
        logic [23:0]      shift;
        ddc_pkg::ddc_pair_t inreg;
        ddc_pkg::ddc_pair_t conv;
        logic [1:0]       dirty;
        ddc_pkg::ddc_pwr_t pwr;
        logic [1:0]       auto_ld;
        logic             done;
    } ddc_state_t;

    ddc_state_t s_q;
    ddc_state_t s_d;

    localparam logic [15:0] RST_CODE =
        MIDSCALE_VARIANT ? ddc_pkg::MID_CODE : ddc_pkg::ZERO_CODE;

    always_comb begin
        logic        fall;
        logic        fs_low;
        logic        fs_fell;
        logic [23:0] fr;
        logic [2:0]  cmd;
        logic [2:0]  chn;
        logic [15:0] dat;
        logic [1:0]  sel;
        logic [1:0]  wr;
        logic [1:0]  upd;
        logic        ldn;
        s_d = s_q;
        fall = 1'b0;
        fs_low = 1'b0;
        fs_fell = 1'b0;
        fr = '0;
        cmd = 3'h0;
        chn = 3'h0;
        dat = 16'h0000;
        sel = 2'h0;
        wr = 2'h0;
        upd = 2'h0;
        ldn = 1'b1;
        // Bit 0 of each synchroniser is only fed forward.
        s_d.fs_s = {s_q.fs_s[1:0], FRAME_SELECT_N};
        s_d.sck_s = {s_q.sck_s[1:0], SERIAL_CLK};
        s_d.sdi_s = {s_q.sdi_s[0], SERIAL_DATA_IN};
        s_d.ld_s = {s_q.ld_s[0], LOAD_STROBE_N};
        s_d.clr_s = {s_q.clr_s[0], CLEAR_INPUT_N};
        s_d.por = 1'b0;
        s_d.done = 1'b0;
        fall = s_q.sck_s[2] & ~s_q.sck_s[1];
        fs_low = ~s_q.fs_s[1];
        fs_fell = s_q.fs_s[2] & ~s_q.fs_s[1];
        ldn = s_q.por ? 1'b1 : s_q.ld_s[1];
        case (s_q.st)
            ddc_pkg::ST_IDLE: begin
                if (fs_fell) begin
                    s_d.st = ddc_pkg::ST_SHIFT;
                    s_d.cnt = ddc_pkg::CNT_RST;
                    s_d.shift = '0;
                end
            end
            ddc_pkg::ST_SHIFT: begin
                if (!fs_low) begin
                    s_d.st = ddc_pkg::ST_IDLE;
                    s_d.shift = '0;
                    s_d.cnt = ddc_pkg::CNT_RST;
                end else if (fall) begin
                    fr = {s_q.shift[22:0], s_q.sdi_s[1]};
                    s_d.shift = fr;
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == ddc_pkg::CNT_LAST) begin
                        s_d.st = ddc_pkg::ST_DONE;
                        s_d.done = 1'b1;
                    end
                end
            end
            ddc_pkg::ST_DONE: begin
                if (!fs_low) begin
                    s_d.st = ddc_pkg::ST_IDLE;
                end
            end
            default: s_d.st = ddc_pkg::ST_IDLE;
        endcase
        if (s_d.done) begin
            cmd = fr[ddc_pkg::CMD_HI:ddc_pkg::CMD_LO];
            chn = fr[ddc_pkg::CHN_HI:ddc_pkg::CHN_LO];
            dat = fr[15:0];
            case (chn)
                ddc_pkg::CHN_A:   sel = 2'b01;
                ddc_pkg::CHN_B:   sel = 2'b10;
                ddc_pkg::CHN_ALL: sel = 2'b11;
                default:          sel = 2'b00;
            endcase
            case (cmd)
                ddc_pkg::CMD_WRITE_IN:  wr = sel;
                ddc_pkg::CMD_UPDATE:    upd = sel;
                ddc_pkg::CMD_WRITE_ALL: begin
                    wr = sel;
                    // A reserved channel code must not update anything.
                    upd = (sel != 2'b00) ? 2'b11 : 2'b00;
                end
                ddc_pkg::CMD_WRITE_UPD: begin
                    wr = sel;
                    upd = sel;
                end
                ddc_pkg::CMD_POWER: begin
                    if (dat[ddc_pkg::SEL_A_BIT]) begin
                        s_d.pwr.mode_a = ddc_pkg::ddc_pd_t'(
                            dat[ddc_pkg::PD_MODE_HI:ddc_pkg::PD_MODE_LO]);
                    end
                    if (dat[ddc_pkg::SEL_B_BIT]) begin
                        s_d.pwr.mode_b = ddc_pkg::ddc_pd_t'(
                            dat[ddc_pkg::PD_MODE_HI:ddc_pkg::PD_MODE_LO]);
                    end
                end
                ddc_pkg::CMD_LOAD_CTL: s_d.auto_ld = dat[1:0];
                default: ;
            endcase
            wr = (cmd == ddc_pkg::CMD_RSVD) ? 2'b00 : wr;
            // Auto-load channels update on this edge regardless of strobe.
            upd = upd | (wr & s_d.auto_ld);
        end
        if (wr[0]) s_d.inreg.code_a = dat;
        if (wr[1]) s_d.inreg.code_b = dat;
        s_d.dirty = s_q.dirty | wr;
        // Level-sensitive strobe; only freshly written inputs move.
        if (!ldn) upd = upd | s_d.dirty;
        // A powered-down channel keeps its code; a pending write waits so
        // that power-up with the strobe low shows the input value.
        if (s_q.pwr.mode_a != ddc_pkg::PD_NORMAL) upd[0] = 1'b0;
        if (s_q.pwr.mode_b != ddc_pkg::PD_NORMAL) upd[1] = 1'b0;
        if (upd[0]) begin
            s_d.conv.code_a = s_d.inreg.code_a;
            s_d.dirty[0] = 1'b0;
        end
        if (upd[1]) begin
            s_d.conv.code_b = s_d.inreg.code_b;
            s_d.dirty[1] = 1'b0;
        end
        if (s_d.done && cmd == ddc_pkg::CMD_RESET) begin
            s_d.inreg = '0;
            s_d.conv = '0;
            s_d.dirty = 2'b00;
            if (dat[0]) begin
                s_d.auto_ld = 2'b00;
                s_d.pwr = '0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            s_q <= '0;
            // Frame select resets low so a pin idling low gives no false start.
            s_q.fs_s <= 3'h0;
            s_q.conv <= {RST_CODE, RST_CODE};
            s_q.sck_s <= 3'h7;
            s_q.ld_s <= 2'h3;
            s_q.clr_s <= 2'h3;
            s_q.por <= 1'b1;
            s_q.st <= ddc_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // The power-on code sits in the converter registers until a frame.
    assign CONV_CODE = s_q.conv;

    assign POWER_MODE = s_q.pwr;
    assign AUTO_LOAD = s_q.auto_ld;
    assign FRAME_DONE = s_q.done;
endmodule

// file: test/ddc_cmd_unit_monitor.sv
// Port checker for the dual converter command unit.
`timescale 1ns/10ps
module ddc_cmd_unit_monitor (
    input wire logic         SYS_CLK,
    input wire logic         RESET,
    input wire logic         FRAME_SELECT_N,
    input wire logic         SERIAL_CLK,
    input wire logic         LOAD_STROBE_N,
    input ddc_pkg::ddc_pair_t CONV_CODE,
    input ddc_pkg::ddc_pwr_t  POWER_MODE,
    input wire logic [1:0]   AUTO_LOAD,
    input wire logic         FRAME_DONE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    a_done_spaced: assert property (
        FRAME_DONE |=> !FRAME_DONE [*8]) else $error("done too close");
    a_clk_idle: assert property (
        $stable(SERIAL_CLK) [*6] |-> !FRAME_DONE) else $error("done idle");
    a_abort_quiet: assert property (
        FRAME_SELECT_N [*8] |-> !FRAME_DONE) else $error("done aborted");
    a_pwr_steady: assert property (
        $changed(POWER_MODE) |-> FRAME_DONE) else $error("mode moved");
    a_ald_steady: assert property (
        $changed(AUTO_LOAD) |-> FRAME_DONE) else $error("load ctl moved");
    a_code_latched: assert property (
        LOAD_STROBE_N [*6] ##0 !FRAME_DONE |-> $stable(CONV_CODE))
        else $error("code moved while latched");
    a_pd_keep_a: assert property (
        $past(POWER_MODE.mode_a) != 2'h0 && !FRAME_DONE
        |-> $stable(CONV_CODE.code_a)) else $error("code a moved in pd");
    a_pd_keep_b: assert property (
        $past(POWER_MODE.mode_b) != 2'h0 && !FRAME_DONE
        |-> $stable(CONV_CODE.code_b)) else $error("code b moved in pd");
    c_frame: cover property (FRAME_DONE);
    c_tri: cover property (POWER_MODE.mode_b == 2'h3);
    c_auto: cover property (AUTO_LOAD == 2'h3);
endmodule
bind ddc_cmd_unit ddc_cmd_unit_monitor ddc_cmd_unit_monitor_i (
    .SYS_CLK, .RESET, .FRAME_SELECT_N, .SERIAL_CLK, .LOAD_STROBE_N,
    .CONV_CODE, .POWER_MODE, .AUTO_LOAD, .FRAME_DONE);

// file: test/ddc_host.sv
// Serial host model that writes frames to the command unit.
`timescale 1ns/10ps
module ddc_host (
    input  wire logic clk,
    output logic      fs_n,
    output logic      sclk,
    output logic      sdi
);
    initial begin
        fs_n = 1'b0;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    task automatic send(input logic [23:0] w, input int n);
        fs_n = 1'b1;
        repeat (4) @(negedge clk);
        fs_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            sdi = ~w[i];
            repeat (2) @(negedge clk);
            sdi = w[i];
            repeat (2) @(negedge clk);
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            sclk = 1'b1;
        end
        fs_n = n > 23 ? 1'b0 : 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

// file: test/tb_ddc_cmd_unit.sv
// Self-checking bench for the dual converter command unit.
`timescale 1ns/10ps
module tb_ddc_cmd_unit;
    logic sys_clk, reset, ls_n, fs_n, sclk, sdi, done;
    ddc_pkg::ddc_pair_t conv_code;
    ddc_pkg::ddc_pwr_t  power_mode;
    logic [1:0]  auto_load, ald, dty;
    logic [37:0] exp_q[$];
    logic [15:0] inr[2], cv[2];
    logic [1:0]  md[2];
    logic [23:0] w;
    int          fails, compares, seed;
    ddc_host ddc_host_i (.clk(sys_clk), .fs_n(fs_n), .sclk(sclk), .sdi(sdi));
    ddc_cmd_unit ddc_cmd_unit_i (.SYS_CLK(sys_clk), .RESET(reset),
        .FRAME_SELECT_N(fs_n), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(sdi),
        .LOAD_STROBE_N(ls_n), .CLEAR_INPUT_N(1'b1), .CONV_CODE(conv_code),
        .POWER_MODE(power_mode), .AUTO_LOAD(auto_load), .FRAME_DONE(done));
    task automatic chk(input logic [37:0] s, input logic [37:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic void cp();
        for (int i = 0; i < 2; i++)
            if (!ls_n && dty[i] && md[i] == 2'h0) begin
                cv[i] = inr[i];
                dty[i] = 1'b0;
            end
    endfunction
    function automatic void apply(logic [23:0] f);
        logic [2:0] c;
        logic [1:0] s;
        c = f[21:19];
        s = f[18:16] == 3'h7 ? 2'h3 : f[18:17] == 2'h0 ? 2'h1 << f[16]
            : 2'h0;
        cp();
        for (int i = 0; i < 2; i++) begin
            if (c == 3'h4 && f[i])
                md[i] = f[5:4];
            if (c != 3'h1 && c < 3'h4 && s[i]) begin
                inr[i] = f[15:0];
                dty[i] = 1'b1;
            end
            if (dty[i] && md[i] == 2'h0 && (c == 3'h2 && s != 2'h0 || s[i]
                && (c == 3'h1 || c == 3'h3 || c == 3'h0 && ald[i]))) begin
                cv[i] = inr[i];
                dty[i] = 1'b0;
            end
            if (c == 3'h5) begin
                {inr[i], cv[i], dty[i]} = '0;
                if (f[0])
                    md[i] = 2'h0;
            end
        end
        if (c == 3'h6 || c == 3'h5 && f[0])
            ald = c == 3'h6 ? f[1:0] : 2'h0;
        cp();
        exp_q.push_back({cv[0], cv[1], md[0], md[1], ald});
    endfunction
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk)
        if (done === 1'b1) begin
            chk(exp_q.size() != 0, 38'h1);
            repeat (2) @(negedge sys_clk);
            chk({conv_code, power_mode, auto_load}, exp_q.pop_front());
        end
    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end
    initial begin
        seed = 32'h754e;
        reset = 1'b1;
        ls_n = 1'b1;
        {inr[0], inr[1], cv[0], cv[1], md[0], md[1], ald, dty} = '0;
        fails = 0;
        compares = 0;
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({conv_code, power_mode, auto_load}, 38'h0);
        for (int k = 0; k < 90; k++) begin
            w = $random(seed);
            ls_n = w[22];
            if (w[23])
                w[18:17] = {2{w[16]}};
            if (w[15:13] == 3'h0)
                ddc_host_i.send(w, 1 + w[12:8] % 23);
            else begin
                apply(w);
                ddc_host_i.send(w, 24);
            end
        end
        repeat (10) @(negedge sys_clk);
        chk(exp_q.size(), 38'h0);
        wrap_up();
    end
endmodule
